/* core/sdram_command_interface.sv */
// Command decoder, bank tracker, burst engine and data path of the DRAM device
// Behaviour
// - Address carries 12-bit row at activate, 8-bit column at read/write.
// - Precharge with address bit 10 set closes all banks, else selected bank.
// - Bank-select inputs pick the bank at activate and column commands.
// - Chip-select high ignores new commands; running burst continues.
// - Inputs sampled on rising edge; strobes decode the operation.
// - Read byte mask high tri-states that lane two cycles later.
// - Write byte mask high blocks that lane in the same cycle.
// - Clock gate low enters power-down, clock-suspend or self-refresh.
// - All strobes low sets mode word from the address inputs.
// - Row strobe high, column strobe low: write-select picks read or write.
// - Read or write commands accepted every cycle, any open bank.
// - Read encoded with chip-select, column strobe low, others high.
// - Mode word sets burst type and length 1, 2, 4, 8 or page.
// - Sequential bursts increment and wrap inside the aligned block.
// - Interleaved bursts use start column XOR beat index.
// - Precharge encoded with chip-select, row strobe, write-select low.
`timescale 1ns/1ps
module sdram_command_interface
    import sdram_cmd_pkg::*;
(
    input  wire logic                             core_clk,
    input  wire logic                             srst,
    input  wire logic                             chipSelectN,
    input  wire logic                             rowStrobeN,
    input  wire logic                             colStrobeN,
    input  wire logic                             writeSelectN,
    input  wire logic                             clockGate,
    input  wire logic [sdram_cmd_pkg::ROW_W-1:0]  address,
    input  wire logic                             bankSelectLo,
    input  wire logic                             bankSelectHi,
    input  wire logic                             upperByteMask,
    input  wire logic                             lowerByteMask,
    input  wire logic [sdram_cmd_pkg::DATA_W-1:0] dataLinesIn,
    output logic      [sdram_cmd_pkg::DATA_W-1:0] dataLinesOut,
    output logic      [sdram_cmd_pkg::DATA_W-1:0] dataLinesOe,
    output logic                                  arrRdEn,
    output logic      [sdram_cmd_pkg::BANK_W-1:0] arrRdBank,
    output logic      [sdram_cmd_pkg::ROW_W-1:0]  arrRdRow,
    output logic      [sdram_cmd_pkg::COL_W-1:0]  arrRdCol,
    input  wire logic [sdram_cmd_pkg::DATA_W-1:0] arrRdData,
    output logic                                  arrWrValid,
    input  wire logic                             arrWrReady,
    output logic      [sdram_cmd_pkg::BANK_W-1:0] arrWrBank,
    output logic      [sdram_cmd_pkg::ROW_W-1:0]  arrWrRow,
    output logic      [sdram_cmd_pkg::COL_W-1:0]  arrWrCol,
    output logic      [sdram_cmd_pkg::DATA_W-1:0] arrWrData,
    output logic      [sdram_cmd_pkg::MASK_W-1:0] arrWrByteEn,
    output logic      [sdram_cmd_pkg::NBANK-1:0]  bankOpen,
    output logic                                  powerDownMode,
    output logic                                  clockSuspendMode,
    output logic                                  selfRefreshMode,
    output logic                                  writeFifoReady,
    output logic                                  writeOverrun
);
    import sdram_cmd_pkg::*;

    logic [ROW_W-1:0]  mode_q;
    logic [ROW_W-1:0]  openRow_q [NBANK];
    power_t            powerState_q;
    power_t            power_d;
    logic              burstActive_q;
    logic              burstWrite_q;
    logic [BANK_W-1:0] burstBank_q;
    logic [COL_W-1:0]  burstStart_q;
    logic [COL_W-1:0]  beat_q;
    logic              rdStageA_q;
    logic              rdStageB_q;
    logic [DATA_W-1:0] rdData_q;
    logic [MASK_W-1:0] maskA_q;
    logic [MASK_W-1:0] maskB_q;
    logic [WQ_W-1:0]   fifoOut;
    logic [WQ_W-1:0]   fifoIn;
    logic              fifoInReady;

    logic [2:0]        cmdCode;
    logic [BANK_W-1:0] cmdBank;
    logic              cmdLive;
    logic              isRead;
    logic              isWrite;
    logic              selfRefreshCmd;
    logic [2:0]        blCode;
    logic              interleave;
    logic              casThree;
    logic              singleWrite;
    logic [COL_W-1:0]  lenMask;
    logic              beatFire;
    logic              beatWrite;
    logic [BANK_W-1:0] beatBank;
    logic [COL_W-1:0]  beatCol;
    logic [MASK_W-1:0] maskNow;
    logic              outValid;
    logic [DATA_W-1:0] outData;

    assign cmdCode        = {rowStrobeN, colStrobeN, writeSelectN};
    assign cmdBank        = {bankSelectHi, bankSelectLo};
    // Deselect and a low clock gate both leave the decoder idle
    assign cmdLive        = ~chipSelectN & clockGate
                          & (powerState_q != PWR_SELF_REFRESH);
    assign isRead         = cmdLive & (cmdCode == CMD_READ)
                          & bankOpen[cmdBank];
    assign isWrite        = cmdLive & (cmdCode == CMD_WRITE)
                          & bankOpen[cmdBank];
    assign selfRefreshCmd = ~chipSelectN & ~clockGate & (cmdCode == CMD_REFRESH);
    assign maskNow        = {upperByteMask, lowerByteMask};

    assign blCode      = mode_q[MODE_BL_LSB +: 3];
    assign interleave  = mode_q[MODE_TYPE_BIT];
    assign casThree    = (mode_q[MODE_CL_LSB +: 3] == CL_3);
    assign singleWrite = mode_q[MODE_WB_BIT];
    assign lenMask     = burst_mask(blCode);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mode_q <= MODE_RESET;
        end else if (cmdLive && cmdCode == CMD_MODE_SET && bankOpen == '0) begin
            mode_q <= address;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            bankOpen <= '0;
        end else if (cmdLive && cmdCode == CMD_ACTIVATE) begin
            bankOpen[cmdBank] <= 1'b1;
        end else if (cmdLive && cmdCode == CMD_PRECHARGE) begin
            if (address[PRECHARGE_ALL_FLAG_BIT]) begin
                bankOpen <= '0;
            end else begin
                bankOpen[cmdBank] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (cmdLive && cmdCode == CMD_ACTIVATE) begin
            openRow_q[cmdBank] <= address;
        end
    end

    always_comb begin
        case (powerState_q)
            PWR_SELF_REFRESH: begin
                power_d = clockGate ? PWR_ACTIVE : PWR_SELF_REFRESH;
            end
            default: begin
                if (selfRefreshCmd && bankOpen == '0) begin
                    power_d = PWR_SELF_REFRESH;
                end else if (!clockGate) begin
                    // A burst in flight is suspended rather than powered down
                    power_d = (burstActive_q || arrRdEn || rdStageA_q)
                            ? PWR_SUSPEND : PWR_DOWN;
                end else begin
                    power_d = PWR_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            powerState_q     <= PWR_ACTIVE;
            powerDownMode    <= 1'b0;
            clockSuspendMode <= 1'b0;
            selfRefreshMode  <= 1'b0;
        end else begin
            powerState_q     <= power_d;
            powerDownMode    <= (power_d == PWR_DOWN);
            clockSuspendMode <= (power_d == PWR_SUSPEND);
            selfRefreshMode  <= (power_d == PWR_SELF_REFRESH);
        end
    end

    // A new column command always wins over the beat of the running burst
    always_comb begin
        if (isRead || isWrite) begin
            beatFire  = 1'b1;
            beatWrite = isWrite;
            beatBank  = cmdBank;
            beatCol   = address[COL_W-1:0];
        end else begin
            beatFire  = burstActive_q & clockGate;
            beatWrite = burstWrite_q;
            beatBank  = burstBank_q;
            beatCol   = burst_col(burstStart_q, beat_q, blCode, interleave);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            burstActive_q <= 1'b0;
            burstWrite_q  <= 1'b0;
            burstBank_q   <= '0;
            burstStart_q  <= '0;
            beat_q        <= '0;
        end else if (isRead || isWrite) begin
            burstWrite_q  <= isWrite;
            burstBank_q   <= cmdBank;
            burstStart_q  <= address[COL_W-1:0];
            beat_q        <= COL_W'(1);
            burstActive_q <= (lenMask != '0) && !(isWrite && singleWrite);
        end else if (burstActive_q && clockGate) begin
            beat_q <= beat_q + COL_W'(1);
            // Page bursts wrap round the row until a new read or write command arrives
            if (beat_q == lenMask && blCode != BL_PAGE) begin
                burstActive_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            arrRdEn   <= 1'b0;
            arrRdBank <= '0;
            arrRdRow  <= '0;
            arrRdCol  <= '0;
        end else begin
            arrRdEn   <= beatFire & ~beatWrite;
            arrRdBank <= beatBank;
            arrRdRow  <= openRow_q[beatBank];
            arrRdCol  <= beatCol;
        end
    end

    // Array answers one cycle after arrRdEn; stage B adds the third cycle
    assign outValid = casThree ? rdStageB_q : rdStageA_q;
    assign outData  = casThree ? rdData_q : arrRdData;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdStageA_q   <= 1'b0;
            rdStageB_q   <= 1'b0;
            rdData_q     <= '0;
            maskA_q      <= '1;
            maskB_q      <= '1;
            dataLinesOut <= '0;
            dataLinesOe  <= '0;
        end else begin
            rdStageA_q   <= arrRdEn;
            rdStageB_q   <= rdStageA_q;
            rdData_q     <= arrRdData;
            maskA_q      <= maskNow;
            maskB_q      <= maskA_q;
            dataLinesOut <= outData;
            dataLinesOe  <= {{LANE_W{outValid & ~maskB_q[1]}},
                             {LANE_W{outValid & ~maskB_q[0]}}};
        end
    end

    // Masked lanes travel with the word as cleared byte enables
    assign fifoIn = {beatBank, openRow_q[beatBank], beatCol, dataLinesIn, ~maskNow};

    write_fifo #(
        .WIDTH (WQ_W),
        .DEPTH (WQ_DEPTH)
    ) writeQueue (
        .core_clk (core_clk),
        .srst     (srst),
        .inValid  (beatFire & beatWrite),
        .inReady  (fifoInReady),
        .inData   (fifoIn),
        .outValid (arrWrValid),
        .outReady (arrWrReady),
        .outData  (fifoOut)
    );

    assign arrWrBank   = fifoOut[WQ_BANK_LSB +: BANK_W];
    assign arrWrRow    = fifoOut[WQ_ROW_LSB +: ROW_W];
    assign arrWrCol    = fifoOut[WQ_COL_LSB +: COL_W];
    assign arrWrData   = fifoOut[WQ_DATA_LSB +: DATA_W];
    assign arrWrByteEn = fifoOut[WQ_EN_LSB +: MASK_W];

    // The bus cannot be stalled, so a lost beat is only reported
    always_ff @(posedge core_clk) begin
        if (srst) begin
            writeFifoReady <= 1'b0;
            writeOverrun   <= 1'b0;
        end else begin
            writeFifoReady <= fifoInReady;
            writeOverrun   <= writeOverrun | (beatFire & beatWrite & ~fifoInReady);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // Drive enables are registered, so they are seen one edge after they change
    sequence readCl3MaskOff;
        (isRead && casThree && maskNow == '0) ##1 (maskNow == '0);
    endsequence

    chk_read_cl_two: assert property (
        (isRead && !casThree && maskNow == '0) |-> ##3 (dataLinesOe == '1))
        else $error("read data not driven two cycles after read");
    chk_read_cl_three: assert property (
        readCl3MaskOff |-> ##3 (dataLinesOe == '1))
        else $error("read data not driven three cycles after read");
    chk_mask_hiz: assert property (
        (maskNow == '1) |-> ##3 (dataLinesOe == '0))
        else $error("masked lanes driven two cycles after mask");
    chk_write_mask: assert property (
        (isWrite && fifoInReady) |-> (fifoIn[WQ_EN_LSB +: MASK_W] == ~maskNow))
        else $error("write byte enables do not follow the mask");
    chk_cs_ignore: assert property (
        (chipSelectN && clockGate) |=> ($stable(bankOpen) && $stable(mode_q)))
        else $error("command taken while chip select high");
    chk_precharge_all: assert property (
        (cmdLive && cmdCode == CMD_PRECHARGE && address[PRECHARGE_ALL_FLAG_BIT])
        |=> (bankOpen == '0))
        else $error("precharge all left a bank open");
    chk_activate_row: assert property (
        (cmdLive && cmdCode == CMD_ACTIVATE)
        |=> (bankOpen[$past(cmdBank)] && openRow_q[$past(cmdBank)] == $past(address)))
        else $error("activate did not open the bank and row");
    chk_mode_load: assert property (
        (cmdLive && cmdCode == CMD_MODE_SET && bankOpen == '0) |=> (mode_q == $past(address)))
        else $error("mode word not loaded");
    chk_seq_beat: assert property (
        (isRead && blCode == BL_4 && !interleave) ##1 (clockGate && !isRead && !isWrite)
        |=> (arrRdCol[COL_W-1:2] == burstStart_q[COL_W-1:2]
             && arrRdCol[1:0] == burstStart_q[1:0] + 2'h1))
        else $error("sequential second beat column wrong");
    chk_ilv_beat: assert property (
        (isRead && blCode == BL_8 && interleave) ##1 (clockGate && !isRead && !isWrite)
        |=> (arrRdCol == (burstStart_q ^ 8'h01)))
        else $error("interleaved second beat column wrong");
endmodule : sdram_command_interface

/* core/sdram_cmd_pkg.sv */
// Constants, command codes and burst helpers for the DRAM command interface
package sdram_cmd_pkg;
    localparam int ROW_W  = 12;
    localparam int COL_W  = 8;
    localparam int BANK_W = 2;
    localparam int NBANK  = 4;
    localparam int DATA_W = 16;
    localparam int MASK_W = 2;
    localparam int LANE_W = 8;

    // Command code is {rowStrobeN, colStrobeN, writeSelectN}
    localparam logic [2:0] CMD_MODE_SET   = 3'h0;
    localparam logic [2:0] CMD_REFRESH    = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE  = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE   = 3'h3;
    localparam logic [2:0] CMD_WRITE      = 3'h4;
    localparam logic [2:0] CMD_READ       = 3'h5;
    localparam logic [2:0] CMD_BURST_STOP = 3'h6;
    localparam logic [2:0] CMD_IDLE       = 3'h7;

    localparam int PRECHARGE_ALL_FLAG_BIT = 10;

    // Mode word fields
    localparam int MODE_BL_LSB   = 0;
    localparam int MODE_TYPE_BIT = 3;
    localparam int MODE_CL_LSB   = 4;
    localparam int MODE_WB_BIT   = 9;
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_3    = 3'h3;
    // Content is undefined after power-up; a definite value keeps simulation clean
    localparam logic [ROW_W-1:0] MODE_RESET = 12'h020;

    // Write queue word: {bank, row, col, data, byte enables}
    localparam int WQ_EN_LSB   = 0;
    localparam int WQ_DATA_LSB = WQ_EN_LSB + MASK_W;
    localparam int WQ_COL_LSB  = WQ_DATA_LSB + DATA_W;
    localparam int WQ_ROW_LSB  = WQ_COL_LSB + COL_W;
    localparam int WQ_BANK_LSB = WQ_ROW_LSB + ROW_W;
    localparam int WQ_W        = WQ_BANK_LSB + BANK_W;
    localparam int WQ_DEPTH    = 8;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_DOWN,
        PWR_SUSPEND,
        PWR_SELF_REFRESH
    } power_t;

    function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] blCode);
        case (blCode)
            BL_2:    return 8'h01;
            BL_4:    return 8'h03;
            BL_8:    return 8'h07;
            BL_PAGE: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction : burst_mask

    function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                   input logic [COL_W-1:0] beat,
                                                   input logic [2:0]       blCode,
                                                   input logic             interleave);
        logic [COL_W-1:0] lowMask;
        logic [COL_W-1:0] offs;
        lowMask = burst_mask(blCode);
        offs    = interleave ? (start ^ beat) : (start + beat);
        return (start & ~lowMask) | (offs & lowMask);
    endfunction : burst_col
endpackage : sdram_cmd_pkg

/* core/write_fifo.sv */
// Small FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ps
module write_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [CNT_W-1:0] count_q;
    logic             push;
    logic             load;

    assign inReady = (count_q != CNT_W'(DEPTH));
    assign push    = inValid & inReady;
    // Refill the output register whenever it is empty or being taken
    assign load    = (count_q != '0) && (!outValid || outReady);

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (load) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            case ({push, load})
                2'b10:   count_q <= count_q + 1'b1;
                2'b01:   count_q <= count_q - 1'b1;
                default: count_q <= count_q;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            outValid <= 1'b0;
            outData  <= '0;
        end else if (load) begin
            outValid <= 1'b1;
            outData  <= mem[rdPtr_q];
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end
endmodule : write_fifo

/* testbench/dram_array_model.sv */
// Behavioural storage array behind the device: registered reads, stallable writes
`timescale 1ns/1ps
module dram_array_model
    import sdram_cmd_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              arrRdEn,
    input  wire logic [BANK_W-1:0] arrRdBank,
    input  wire logic [ROW_W-1:0]  arrRdRow,
    input  wire logic [COL_W-1:0]  arrRdCol,
    output logic      [DATA_W-1:0] arrRdData,
    output logic                   arrWrReady,
    input  wire logic              hold
);
    initial arrRdData = 16'h0000;
    assign arrWrReady = ~hold;
    // Word encodes its own address; idle cycles toggle so stale words never match
    always @(posedge core_clk) begin
        if (arrRdEn) begin
            arrRdData <= {arrRdBank, arrRdRow[5:0], arrRdCol};
        end else begin
            arrRdData <= ~arrRdData;
        end
    end
endmodule : dram_array_model

/* testbench/sdram_command_interface_tb.sv */
// Random and corner-case bench for the DRAM command interface
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] %0t mismatch", $time); end end
module sdram_command_interface_tb;
    import sdram_cmd_pkg::*;
    logic core_clk = 1'b0, srst = 1'b1, chipSelectN = 1'b0, clockGate = 1'b1, hold = 1'b0;
    logic rowStrobeN = 1'b1, colStrobeN = 1'b1, writeSelectN = 1'b1;
    logic bankSelectLo = 1'b0, bankSelectHi = 1'b0, upperByteMask = 1'b1, lowerByteMask = 1'b1;
    logic [11:0] address = 12'h000, arrRdRow, arrWrRow, row;
    logic [15:0] dataLinesIn = 16'h0000, dataLinesOut, dataLinesOe, arrRdData, arrWrData;
    logic [15:0] rnd = 16'h26F0;
    logic        arrRdEn, arrWrValid, arrWrReady, powerDownMode, writeOverrun;
    logic        clockSuspendMode, selfRefreshMode, writeFifoReady;
    logic [1:0]  arrRdBank, arrWrBank, arrWrByteEn;
    logic [7:0]  arrRdCol, arrWrCol;
    logic [3:0]  bankOpen;
    logic [39:0] expQ[$], gotQ[$];
    int          num_errors = 0, checks_done = 0, cycles = 0;
    // Power-up pause of 200 us at 10 ns a cycle
    localparam int PAUSE_CYCLES = 20000;

    always #5 core_clk = ~core_clk;

    sdram_command_interface u_dut (.core_clk, .srst, .chipSelectN, .rowStrobeN, .colStrobeN,
        .writeSelectN, .clockGate, .address, .bankSelectLo, .bankSelectHi, .upperByteMask,
        .lowerByteMask, .dataLinesIn, .dataLinesOut, .dataLinesOe, .arrRdEn, .arrRdBank,
        .arrRdRow, .arrRdCol, .arrRdData, .arrWrValid, .arrWrReady, .arrWrBank, .arrWrRow,
        .arrWrCol, .arrWrData, .arrWrByteEn, .bankOpen, .powerDownMode, .clockSuspendMode,
        .selfRefreshMode, .writeFifoReady, .writeOverrun);
    dram_array_model u_arr (.core_clk, .arrRdEn, .arrRdBank, .arrRdRow, .arrRdCol,
        .arrRdData, .arrWrReady, .hold);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    always @(posedge core_clk) begin
        cycles++;
        if (arrWrValid === 1'b1 && arrWrReady)
            gotQ.push_back({arrWrBank, arrWrRow, arrWrCol, arrWrData, arrWrByteEn});
        if (cycles == PAUSE_CYCLES + 2000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
        @(posedge core_clk);
        #1;
        {rowStrobeN, colStrobeN, writeSelectN} = c;
        {bankSelectHi, bankSelectLo} = b;
        address = a;
    endtask : cmd

    task automatic idle(input int n);
        repeat (n) cmd(CMD_IDLE, 2'h0, 12'h000);
    endtask : idle

    // With msk set: upper mask on the command edge, lower mask one edge later
    task automatic rd(input logic [1:0] b, input logic [7:0] col, input int cl, bl, inter,
                      input logic msk);
        logic [7:0] m;
        logic [7:0] e;
        int         mu;
        int         ml;
        m = 8'(bl - 1);
        mu = msk ? 2 - cl : -1;
        ml = msk ? 3 - cl : -1;
        cmd(CMD_READ, b, {4'h0, col});
        upperByteMask = msk;
        cmd(CMD_IDLE, 2'h0, 12'h000);
        upperByteMask = 1'b0;
        lowerByteMask = msk;
        @(posedge core_clk);
        #1;
        lowerByteMask = 1'b0;
        repeat (cl - 1) @(posedge core_clk);
        #1;
        for (int k = 0; k < bl; k++) begin
            e = inter ? col ^ 8'(k) : col + 8'(k);
            e = (col & ~m) | (e & m);
            `CHK(dataLinesOe, {k == mu ? 8'h00 : 8'hFF, k == ml ? 8'h00 : 8'hFF})
            `CHK(dataLinesOut & dataLinesOe, {b, row[5:0], e} & dataLinesOe)
            @(posedge core_clk);
            #1;
        end
        `CHK(dataLinesOe, 16'h0000)
    endtask : rd

    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        srst = 1'b0;
        `CHK(bankOpen, 4'h0)
        // Masks and clock gate stay high through the pause
        idle(PAUSE_CYCLES);
        upperByteMask = 1'b0;
        lowerByteMask = 1'b0;
        cmd(CMD_PRECHARGE, 2'h0, 12'h400);
        repeat (8) cmd(CMD_REFRESH, 2'h0, 12'h000);
        rnd = lfsr(rnd);
        row = rnd[11:0];
        cmd(CMD_MODE_SET, 2'h0, 12'h002);
        idle(2);
        cmd(CMD_ACTIVATE, 2'h1, row);
        idle(2);
        `CHK(bankOpen, 4'h2)
        rd(2'h1, 8'h06, 2, 4, 0, 1'b1);
        rd(2'h1, rnd[15:8], 2, 4, 0, 1'b0);
        $display("sequential read test done");
        cmd(CMD_PRECHARGE, 2'h0, 12'h400);
        idle(1);
        `CHK(bankOpen, 4'h0)
        cmd(CMD_MODE_SET, 2'h0, 12'h03B);
        idle(2);
        cmd(CMD_ACTIVATE, 2'h2, row);
        cmd(CMD_ACTIVATE, 2'h0, 12'h000);
        idle(2);
        rnd = lfsr(rnd);
        rd(2'h2, rnd[7:0], 3, 8, 1, 1'b1);
        rd(2'h2, rnd[15:8], 3, 8, 1, 1'b0);
        chipSelectN = 1'b1;
        cmd(CMD_PRECHARGE, 2'h2, 12'h400);
        idle(1);
        chipSelectN = 1'b0;
        `CHK(bankOpen, 4'h5)
        cmd(CMD_PRECHARGE, 2'h2, 12'h000);
        idle(1);
        `CHK(bankOpen, 4'h1)
        $display("interleave and precharge test done");
        cmd(CMD_PRECHARGE, 2'h0, 12'h400);
        idle(1);
        cmd(CMD_MODE_SET, 2'h0, 12'h000);
        idle(2);
        cmd(CMD_ACTIVATE, 2'h3, row);
        idle(2);
        hold = 1'b1;
        // Nine words fit behind a stalled array; the tenth is lost
        for (int i = 0; i < 10; i++) begin
            rnd = lfsr(rnd);
            cmd(CMD_WRITE, 2'h3, {4'h0, 8'(i)});
            dataLinesIn = rnd;
            {upperByteMask, lowerByteMask} = rnd[1:0];
            if (i < 9) expQ.push_back({2'h3, row, 8'(i), rnd, ~rnd[1:0]});
        end
        cmd(CMD_IDLE, 2'h0, 12'h000);
        {upperByteMask, lowerByteMask} = 2'h0;
        idle(2);
        `CHK(writeOverrun, 1'b1)
        `CHK(writeFifoReady, 1'b0)
        hold = 1'b0;
        idle(14);
        `CHK(writeFifoReady, 1'b1)
        `CHK(gotQ.size(), 9)
        foreach (expQ[i]) `CHK(gotQ[i], expQ[i])
        $display("write stall test done");
        // A read still in flight turns a low clock gate into suspend
        cmd(CMD_READ, 2'h3, 12'h000);
        cmd(CMD_IDLE, 2'h0, 12'h000);
        clockGate = 1'b0;
        idle(1);
        `CHK(clockSuspendMode, 1'b1)
        idle(2);
        `CHK(powerDownMode, 1'b1)
        clockGate = 1'b1;
        cmd(CMD_PRECHARGE, 2'h0, 12'h400);
        cmd(CMD_REFRESH, 2'h0, 12'h000);
        clockGate = 1'b0;
        idle(1);
        `CHK(selfRefreshMode, 1'b1)
        clockGate = 1'b1;
        idle(1);
        `CHK(selfRefreshMode, 1'b0)
        $display("power test done");
        end_sim();
    end
endmodule : sdram_command_interface_tb
